// ==== hw/epmc_pkg.sv ====
package epmc_pkg;

	// ----------------------------------------------------------------
	// register map
	// ----------------------------------------------------------------
	localparam logic [7:0] PWR_CTRL_OFS = 8'h84;
	localparam logic [7:0] WAKE_TRIGGER_OFS = 8'h64;

	// ----------------------------------------------------------------
	// control register fields
	// ----------------------------------------------------------------
	localparam int PS_LSB = 12;
	localparam int XCVR_RST_BIT = 10;
	localparam int FRAME_WAKE_EN_BIT = 9;
	localparam int ENERGY_WAKE_EN_BIT = 8;
	localparam int DRIVE_TYPE_BIT = 6;
	localparam int STAT_FRAME_BIT = 5;
	localparam int STAT_ENERGY_BIT = 4;
	localparam int PULSE_SEL_BIT = 3;
	localparam int POLARITY_BIT = 2;
	localparam int PIN_EN_BIT = 1;
	localparam int READY_BIT = 0;

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [1:0] PS_RESET = 2'h0;
	localparam logic [1:0] STAT_RESET = 2'h0;
	localparam logic CTRL_BIT_RESET = 1'h0;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 50;
	localparam int XCVR_RST_HOLD_NS = 100000;
	localparam int XCVR_RST_CYCLES =
		(XCVR_RST_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int WAKE_PULSE_MS = 50;
	localparam int WAKE_PULSE_CYCLES =
		WAKE_PULSE_MS * 1000000 / CLK_PERIOD_NS;
	localparam int SETTLE_NS = 1000;
	localparam int SETTLE_CYCLES =
		(SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		full_power_state = 2'b00,
		frame_wake_state = 2'b01,
		energy_wake_state = 2'b10
	} epmc_power_state_t;

	typedef enum logic [1:0] {
		seq_run = 2'b00,
		seq_sleep = 2'b01,
		seq_settle = 2'b10
	} epmc_seq_t;

endpackage

// ==== hw/epmc_pin_if.sv ====
`timescale 1ns/1ps
interface epmc_pin_if;
	logic active;
	logic push_pull;
	logic active_high;
	logic pin_out;
	logic pin_oe;

	modport ctl (
		output active,
		output push_pull,
		output active_high,
		input pin_out,
		input pin_oe
	);

	modport drv (
		input active,
		input push_pull,
		input active_high,
		output pin_out,
		output pin_oe
	);
endinterface

// ==== hw/epmc_hold_timer.sv ====
`timescale 1ns/1ps
module epmc_hold_timer #(
	parameter int CYCLES = 2
) (
	// clock and reset
	input wire logic clk,
	input wire logic reset,
	// control
	input wire logic run,
	output logic done
);
	import epmc_pkg::*;

	localparam int W = $clog2(CYCLES + 1);

	logic [W-1:0] cnt_reg;

	// done on the last cycle of a run, so run lasts exactly CYCLES
	assign done = run && (cnt_reg == W'(CYCLES - 1));

	always_ff @(posedge clk)
	begin
		if (reset || !run)
			cnt_reg <= '0;
		else
			cnt_reg <= cnt_reg + 1'b1;
	end
endmodule

// ==== hw/epmc_pin_driver.sv ====
`timescale 1ns/1ps
module epmc_pin_driver (
	// clock and reset
	input wire logic clk,
	input wire logic reset,
	// pin control
	epmc_pin_if.drv pin
);
	import epmc_pkg::*;

	logic out_reg;
	logic oe_reg;

	assign pin.pin_out = out_reg;
	assign pin.pin_oe = oe_reg;

	// open drain: only ever pulls low, polarity ignored
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			oe_reg <= 1'b0;
			out_reg <= 1'b0;
		end
		else if (pin.push_pull)
		begin
			oe_reg <= 1'b1;
			out_reg <= pin.active_high ? pin.active : !pin.active;
		end
		else
		begin
			oe_reg <= pin.active;
			out_reg <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	property p_od_low;
		@(posedge clk) disable iff (reset)
		!pin.push_pull |=> !pin.pin_out;
	endproperty
	a_od_low: assert property (p_od_low)
		else $error("open-drain pin driven high");

	property p_pp_level;
		@(posedge clk) disable iff (reset)
		pin.push_pull |=>
			pin.pin_oe && (pin.pin_out ==
			($past(pin.active_high) ~^ $past(pin.active)));
	endproperty
	a_pp_level: assert property (p_pp_level)
		else $error("push-pull level does not follow polarity");
endmodule

// ==== hw/epmc_power_ctrl.sv ====
`timescale 1ns/1ps
module epmc_power_ctrl #(
	parameter int WAKE_PULSE_LEN = epmc_pkg::WAKE_PULSE_CYCLES,
	parameter logic [7:0] WAKE_TRIGGER_ADDR = epmc_pkg::WAKE_TRIGGER_OFS
) (
	// clock and resets
	input wire logic clk,
	input wire logic reset,
	input wire logic soft_reset,
	// host bus pins
	input wire logic host_cs_n,
	input wire logic host_rd_n,
	input wire logic host_wr_n,
	input wire logic [7:0] host_addr,
	input wire logic [31:0] host_data_in,
	output logic [31:0] host_data_out,
	output logic host_data_oe,
	// wake detectors
	input wire logic wol_event,
	input wire logic energy_event,
	output logic frame_detect_enable,
	output logic energy_detect_enable,
	output logic wake_interrupt,
	output logic device_ready,
	// transceiver
	output logic transceiver_reset,
	// wake event pin
	output logic wake_event_pin_out,
	output logic wake_event_pin_oe
);
	import epmc_pkg::*;

	// ----------------------------------------------------------------
	// host bus synchronisers
	// ----------------------------------------------------------------
	logic [2:0] strb_s1_reg;
	logic [2:0] strb_s2_reg;
	logic [7:0] addr_s1_reg;
	logic [7:0] addr_s2_reg;
	logic [31:0] data_s1_reg;
	logic [31:0] data_s2_reg;
	logic rd_prev_reg;
	logic wr_prev_reg;

	// address and data take the same two stages as the strobes
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			strb_s1_reg <= 3'h7;
			strb_s2_reg <= 3'h7;
			addr_s1_reg <= 8'h00;
			addr_s2_reg <= 8'h00;
			data_s1_reg <= 32'h0;
			data_s2_reg <= 32'h0;
		end
		else
		begin
			strb_s1_reg <= {host_cs_n, host_rd_n, host_wr_n};
			strb_s2_reg <= strb_s1_reg;
			addr_s1_reg <= host_addr;
			addr_s2_reg <= addr_s1_reg;
			data_s1_reg <= host_data_in;
			data_s2_reg <= data_s1_reg;
		end
	end

	logic rd_act;
	logic wr_act;
	logic rd_rise;
	logic wr_take;
	assign rd_act = !strb_s2_reg[2] && !strb_s2_reg[1];
	assign wr_act = !strb_s2_reg[2] && !strb_s2_reg[0];
	assign rd_rise = rd_act && !rd_prev_reg;
	assign wr_take = wr_act && !wr_prev_reg;

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			rd_prev_reg <= 1'b0;
			wr_prev_reg <= 1'b0;
		end
		else
		begin
			rd_prev_reg <= rd_act;
			wr_prev_reg <= wr_act;
		end
	end

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	epmc_seq_t seq_reg;
	epmc_power_state_t power_state_field_reg;
	logic armed_reg;
	logic transceiver_reset_bit_reg;
	logic frame_wake_enable_reg;
	logic energy_wake_enable_reg;
	logic wake_pin_drive_type_reg;
	logic wake_pin_polarity_reg;
	logic wake_pin_pulse_select_reg;
	logic wake_pin_enable_reg;
	logic [1:0] wake_status_reg;
	logic pulse_reg;
	logic phy_done;
	logic settle_done;
	logic pulse_done;

	logic is_pmt;
	logic wake_cmd;
	logic pmt_wr;
	assign is_pmt = addr_s2_reg == PWR_CTRL_OFS;
	// wake trigger honoured only while asleep
	assign wake_cmd = wr_take && (addr_s2_reg == WAKE_TRIGGER_ADDR)
		&& (seq_reg == seq_sleep);
	// other writes dropped until ready and a read has been seen
	assign pmt_wr = wr_take && is_pmt && armed_reg
		&& (seq_reg == seq_run);

	logic [1:0] ps_wr;
	assign ps_wr = data_s2_reg[PS_LSB+1:PS_LSB];

	always_ff @(posedge clk)
	begin
		if (reset || soft_reset)
			armed_reg <= 1'b0;
		else if (wake_cmd)
			armed_reg <= 1'b0;
		else if (rd_rise)
			armed_reg <= 1'b1;
	end

	// reset also needs settling before ready
	always_ff @(posedge clk)
	begin
		if (reset)
			seq_reg <= seq_settle;
		else
		begin
			unique case (seq_reg)
				seq_run:
					if (pmt_wr && (ps_wr == frame_wake_state
						|| ps_wr == energy_wake_state))
						seq_reg <= seq_sleep;
				seq_sleep:
					if (wake_cmd)
						seq_reg <= seq_settle;
				seq_settle:
					if (settle_done)
						seq_reg <= seq_run;
				default:
					seq_reg <= seq_settle;
			endcase
		end
	end

	// code eleven is refused rather than trusted
	always_ff @(posedge clk)
	begin
		if (reset || soft_reset)
			power_state_field_reg <= epmc_power_state_t'(PS_RESET);
		else if (wake_cmd)
			power_state_field_reg <= full_power_state;
		else if (pmt_wr && (ps_wr == frame_wake_state
			|| ps_wr == energy_wake_state))
			power_state_field_reg <= epmc_power_state_t'(ps_wr);
	end

	assign frame_detect_enable = (seq_reg == seq_sleep)
		&& (power_state_field_reg == frame_wake_state);
	assign energy_detect_enable = (seq_reg == seq_sleep)
		&& (power_state_field_reg == energy_wake_state);
	assign device_ready = seq_reg == seq_run;

	// ----------------------------------------------------------------
	// control bits
	// ----------------------------------------------------------------
	always_ff @(posedge clk)
	begin
		if (reset || soft_reset)
		begin
			frame_wake_enable_reg <= CTRL_BIT_RESET;
			energy_wake_enable_reg <= CTRL_BIT_RESET;
			wake_pin_pulse_select_reg <= CTRL_BIT_RESET;
			wake_pin_enable_reg <= CTRL_BIT_RESET;
		end
		else if (pmt_wr)
		begin
			frame_wake_enable_reg <= data_s2_reg[FRAME_WAKE_EN_BIT];
			energy_wake_enable_reg <= data_s2_reg[ENERGY_WAKE_EN_BIT];
			wake_pin_pulse_select_reg <= data_s2_reg[PULSE_SEL_BIT];
			wake_pin_enable_reg <= data_s2_reg[PIN_EN_BIT];
		end
	end

	// survives soft reset: the board wiring does not change
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			wake_pin_drive_type_reg <= CTRL_BIT_RESET;
			wake_pin_polarity_reg <= CTRL_BIT_RESET;
		end
		else if (pmt_wr)
		begin
			wake_pin_drive_type_reg <= data_s2_reg[DRIVE_TYPE_BIT];
			wake_pin_polarity_reg <= data_s2_reg[POLARITY_BIT];
		end
	end

	// ----------------------------------------------------------------
	// transceiver reset
	// ----------------------------------------------------------------
	always_ff @(posedge clk)
	begin
		if (reset || soft_reset)
			transceiver_reset_bit_reg <= CTRL_BIT_RESET;
		else if (phy_done)
			transceiver_reset_bit_reg <= 1'b0;
		else if (pmt_wr && data_s2_reg[XCVR_RST_BIT]
			&& !transceiver_reset_bit_reg)
			transceiver_reset_bit_reg <= 1'b1;
	end

	assign transceiver_reset = transceiver_reset_bit_reg;

	epmc_hold_timer #(
		.CYCLES(XCVR_RST_CYCLES)
	) u_phy_timer (
		.clk(clk),
		.reset(reset),
		.run(transceiver_reset_bit_reg),
		.done(phy_done)
	);

	epmc_hold_timer #(
		.CYCLES(SETTLE_CYCLES)
	) u_settle_timer (
		.clk(clk),
		.reset(reset),
		.run(seq_reg == seq_settle),
		.done(settle_done)
	);

	// ----------------------------------------------------------------
	// wake events
	// ----------------------------------------------------------------
	logic frame_set;
	logic energy_set;
	logic [1:0] status_clr;
	assign frame_set = wol_event && frame_wake_enable_reg;
	assign energy_set = energy_event && energy_wake_enable_reg;
	assign status_clr = pmt_wr ?
		data_s2_reg[STAT_FRAME_BIT:STAT_ENERGY_BIT] : 2'h0;

	// a new event beats a clear in the same cycle
	always_ff @(posedge clk)
	begin
		if (reset || soft_reset)
			wake_status_reg <= STAT_RESET;
		else
			wake_status_reg <= {frame_set, energy_set}
				| (wake_status_reg & ~status_clr);
	end

	// pin enable does not gate the interrupt
	assign wake_interrupt = |wake_status_reg;

	// a pulse already running is not restarted by a later event
	always_ff @(posedge clk)
	begin
		if (reset || soft_reset)
			pulse_reg <= 1'b0;
		else if (pulse_done)
			pulse_reg <= 1'b0;
		else if ((frame_set || energy_set) && wake_pin_pulse_select_reg)
			pulse_reg <= 1'b1;
	end

	epmc_hold_timer #(
		.CYCLES(WAKE_PULSE_LEN)
	) u_pulse_timer (
		.clk(clk),
		.reset(reset),
		.run(pulse_reg),
		.done(pulse_done)
	);

	// ----------------------------------------------------------------
	// wake pin
	// ----------------------------------------------------------------
	epmc_pin_if pin_bus ();
	logic static_active;
	assign static_active =
		(wake_status_reg[1] && frame_wake_enable_reg)
		|| (wake_status_reg[0] && energy_wake_enable_reg);
	assign pin_bus.active = wake_pin_enable_reg &&
		(wake_pin_pulse_select_reg ? pulse_reg : static_active);
	assign pin_bus.push_pull = wake_pin_drive_type_reg;
	assign pin_bus.active_high = wake_pin_polarity_reg;
	assign wake_event_pin_out = pin_bus.pin_out;
	assign wake_event_pin_oe = pin_bus.pin_oe;

	epmc_pin_driver u_pin (
		.clk(clk),
		.reset(reset),
		.pin(pin_bus.drv)
	);

	// ----------------------------------------------------------------
	// read path
	// ----------------------------------------------------------------
	logic [31:0] pmt_value;
	assign pmt_value = {18'h0, power_state_field_reg, 1'b0,
		transceiver_reset_bit_reg, frame_wake_enable_reg,
		energy_wake_enable_reg, 1'b0, wake_pin_drive_type_reg,
		wake_status_reg, wake_pin_pulse_select_reg,
		wake_pin_polarity_reg, wake_pin_enable_reg, device_ready};

	// readable in every state, other addresses read zero
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			host_data_out <= 32'h0;
			host_data_oe <= 1'b0;
		end
		else
		begin
			host_data_oe <= rd_act;
			if (rd_rise)
				host_data_out <= is_pmt ? pmt_value : 32'h0;
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	logic [11:0] phy_len_reg;
	always_ff @(posedge clk)
	begin
		if (reset || !transceiver_reset_bit_reg)
			phy_len_reg <= 12'h000;
		else
			phy_len_reg <= phy_len_reg + 12'h001;
	end

	property p_mode_legal;
		@(posedge clk) disable iff (reset)
		wr_take |=> power_state_field_reg != 2'b11;
	endproperty
	a_mode_legal: assert property (p_mode_legal)
		else $error("power state holds reserved code");

	property p_phy_hold;
		@(posedge clk) disable iff (reset || soft_reset)
		$fell(transceiver_reset) |->
			$past(phy_len_reg) == 12'(XCVR_RST_CYCLES - 1);
	endproperty
	a_phy_hold: assert property (p_phy_hold)
		else $error("transceiver reset hold length wrong");

	property p_phy_ignore;
		@(posedge clk) disable iff (reset || soft_reset)
		transceiver_reset && !phy_done && pmt_wr |=>
			transceiver_reset && phy_len_reg != 12'h000;
	endproperty
	a_phy_ignore: assert property (p_phy_ignore)
		else $error("transceiver reset restarted by write");

	property p_frame_detect;
		@(posedge clk) disable iff (reset || soft_reset)
		pmt_wr && ps_wr == frame_wake_state
			|=> frame_detect_enable && !device_ready;
	endproperty
	a_frame_detect: assert property (p_frame_detect)
		else $error("frame detection off in frame-wake state");

	property p_energy_detect;
		@(posedge clk) disable iff (reset || soft_reset)
		pmt_wr && ps_wr == energy_wake_state
			|=> energy_detect_enable && !frame_detect_enable;
	endproperty
	a_energy_detect: assert property (p_energy_detect)
		else $error("energy detection off in energy-wake state");

	property p_wake;
		@(posedge clk) disable iff (reset)
		wake_cmd |=> power_state_field_reg == full_power_state
			&& !device_ready ##[18:22] device_ready;
	endproperty
	a_wake: assert property (p_wake)
		else $error("wake trigger did not restore ready");

	property p_unarmed;
		@(posedge clk) disable iff (reset || soft_reset)
		wr_take && !armed_reg |=>
			$stable(wake_pin_enable_reg) && $stable(transceiver_reset);
	endproperty
	a_unarmed: assert property (p_unarmed)
		else $error("write acted before first read");

	property p_wol_int;
		@(posedge clk) disable iff (reset || soft_reset)
		wol_event && frame_wake_enable_reg |=> wake_interrupt;
	endproperty
	a_wol_int: assert property (p_wol_int)
		else $error("frame event lost from interrupt");

	property p_ed_int;
		@(posedge clk) disable iff (reset || soft_reset)
		energy_event && energy_wake_enable_reg |=> wake_status_reg[0];
	endproperty
	a_ed_int: assert property (p_ed_int)
		else $error("energy event lost from status");

	// judged at the pin: inactive level for the selected driver
	property p_pin_gate;
		@(posedge clk) disable iff (reset)
		!wake_pin_enable_reg |=>
			wake_event_pin_oe == $past(wake_pin_drive_type_reg)
			&& !(wake_event_pin_oe
			&& wake_event_pin_out == $past(wake_pin_polarity_reg));
	endproperty
	a_pin_gate: assert property (p_pin_gate)
		else $error("wake pin active while disabled");
endmodule

// ==== bench/epmc_host_model.sv ====
`timescale 1ns/1ps
// ----------------------------------------------------------------
// host processor on the parallel bus
// ----------------------------------------------------------------
module epmc_host_model
(
	// clock and reset
	input wire logic clk,
	input wire logic reset,
	// device side
	input wire logic device_ready,
	input wire logic [31:0] host_data_out,
	input wire logic host_data_oe,
	// bus pins
	output logic host_cs_n,
	output logic host_rd_n,
	output logic host_wr_n,
	output logic [7:0] host_addr,
	output logic [31:0] host_data_in
);
	import epmc_pkg::*;

	// set by a scenario that breaks the host's side on purpose
	logic allow_bad = 1'b0;
	logic read_seen = 1'b0;

	initial
	begin
		host_cs_n = 1'b1;
		host_rd_n = 1'b1;
		host_wr_n = 1'b1;
		host_addr = 8'hFF;
		host_data_in = 32'hFFFFFFFF;
	end

	always @(posedge clk)
		if (reset)
			read_seen <= 1'b0;

	task automatic bus_read(input logic [7:0] a, output logic [31:0] d);
		int n;
		@(posedge clk);
		host_cs_n <= 1'b0;
		host_rd_n <= 1'b0;
		host_addr <= a;
		@(posedge clk);
		for (n = 0; n < 20 && host_data_oe !== 1'b1; n++)
			@(posedge clk);
		d = host_data_out;
		read_seen = 1'b1;
		host_cs_n <= 1'b1;
		host_rd_n <= 1'b1;
		host_addr <= ~a;
		repeat (4) @(posedge clk);
	endtask

	task automatic bus_write(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] v;
		logic [31:0] junk;
		v = d;
		if (!allow_bad && !read_seen)
			bus_read(PWR_CTRL_OFS, junk);
		if (!allow_bad && a == PWR_CTRL_OFS && v[13:12] == 2'h3)
			v[13:12] = 2'h0;
		if (!allow_bad && device_ready !== 1'b1 && a != WAKE_TRIGGER_OFS)
			return;
		@(posedge clk);
		host_cs_n <= 1'b0;
		host_wr_n <= 1'b0;
		host_addr <= a;
		host_data_in <= v;
		repeat (4) @(posedge clk);
		host_cs_n <= 1'b1;
		host_wr_n <= 1'b1;
		host_addr <= ~a;
		host_data_in <= ~v;
		// a wake asks for a fresh read before writes count
		if (a == WAKE_TRIGGER_OFS)
			read_seen = 1'b0;
		repeat (4) @(posedge clk);
	endtask
endmodule

// ==== bench/ethernet_power_management_control_bench.sv ====
`timescale 1ns/1ps
module ethernet_power_management_control_bench;
	import epmc_pkg::*;
	// ----------------------------------------------------------------
	// setup
	// ----------------------------------------------------------------
	localparam int PULSE = 50;
	localparam logic [31:0] PP = 32'h40;
	localparam logic [31:0] POL = 32'h4;
	localparam logic [31:0] EN = 32'h2;
	localparam logic [31:0] WOL = 32'h200;
	localparam logic [31:0] ED = 32'h100;
	localparam logic [31:0] RST = 32'h400;
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic soft_reset = 1'b0;
	logic wol_event = 1'b0;
	logic energy_event = 1'b0;
	logic host_cs_n, host_rd_n, host_wr_n, host_data_oe;
	logic [7:0] host_addr;
	logic [31:0] host_data_in, host_data_out, rd, mode_word;
	logic frame_detect_enable, energy_detect_enable, wake_interrupt;
	logic device_ready, transceiver_reset;
	logic wake_event_pin_out, wake_event_pin_oe;
	// open drain line is pulled up when nobody drives it
	wire pin_level = wake_event_pin_oe ? wake_event_pin_out : 1'b1;
	int err_count = 0;
	int checked = 0;
	int cycles = 0;
	int n;
	logic [31:0] cfg [3] = '{WOL | PP | POL | EN, ED | PP | EN, ED | POL | EN};
	logic evt [3] = '{1'b0, 1'b1, 1'b1};
	logic act [3] = '{1'b1, 1'b0, 1'b0};
	logic [31:0] stat [3] = '{32'h20, 32'h10, 32'h10};

	initial
	begin
		forever #25 clk = ~clk;
	end

	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			err_count++;
			report_and_stop();
		end
	end

	epmc_power_ctrl #(.WAKE_PULSE_LEN(PULSE)) u_dut (
		.clk(clk), .reset(reset), .soft_reset(soft_reset),
		.host_cs_n(host_cs_n), .host_rd_n(host_rd_n),
		.host_wr_n(host_wr_n), .host_addr(host_addr),
		.host_data_in(host_data_in), .host_data_out(host_data_out),
		.host_data_oe(host_data_oe), .wol_event(wol_event),
		.energy_event(energy_event),
		.frame_detect_enable(frame_detect_enable),
		.energy_detect_enable(energy_detect_enable),
		.wake_interrupt(wake_interrupt), .device_ready(device_ready),
		.transceiver_reset(transceiver_reset),
		.wake_event_pin_out(wake_event_pin_out),
		.wake_event_pin_oe(wake_event_pin_oe));

	epmc_host_model u_host (
		.clk(clk), .reset(reset), .device_ready(device_ready),
		.host_data_out(host_data_out), .host_data_oe(host_data_oe),
		.host_cs_n(host_cs_n), .host_rd_n(host_rd_n),
		.host_wr_n(host_wr_n), .host_addr(host_addr),
		.host_data_in(host_data_in));

	// ----------------------------------------------------------------
	// tasks
	// ----------------------------------------------------------------
	task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp)
		begin
			err_count++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic check_bit(input logic got, input logic exp);
		check_word({31'h0, got}, {31'h0, exp});
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
		u_host.bus_read(a, rd);
		check_word(rd, exp);
	endtask

	task automatic tick(input int k);
		repeat (k) @(posedge clk);
	endtask

	task automatic wait_ready();
		for (n = 0; n < 100 && device_ready !== 1'b1; n++)
			@(posedge clk);
		check_bit(device_ready, 1'b1);
	endtask

	task automatic fire(input logic e);
		@(posedge clk);
		wol_event <= !e;
		energy_event <= e;
		@(posedge clk);
		wol_event <= 1'b0;
		energy_event <= 1'b0;
	endtask

	// bounded wait for a rise, then count sampled high cycles
	task automatic count_high(input logic sel, output int k);
		int w;
		for (w = 0; w < 3000
			&& (sel ? pin_level : transceiver_reset) !== 1'b1; w++)
			@(posedge clk);
		for (k = 0; k < 3000
			&& (sel ? pin_level : transceiver_reset) === 1'b1; k++)
			@(posedge clk);
	endtask

	task automatic report_and_stop();
		$display("errors=%0d checks=%0d", err_count, checked);
		if (err_count == 0 && checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// tests
	// ----------------------------------------------------------------
	initial
	begin
		tick(8);
		reset <= 1'b0;
		wait_ready();
		u_host.allow_bad = 1'b1;
		u_host.bus_write(PWR_CTRL_OFS, EN);
		u_host.allow_bad = 1'b0;
		rd_chk(PWR_CTRL_OFS, 32'h1);
		u_host.allow_bad = 1'b1;
		u_host.bus_write(PWR_CTRL_OFS, 32'h3000);
		u_host.allow_bad = 1'b0;
		rd_chk(PWR_CTRL_OFS, 32'h1);
		rd_chk(8'h88, 32'h0);
		fork
			count_high(1'b0, n);
			begin
				u_host.bus_write(PWR_CTRL_OFS, RST);
				rd_chk(PWR_CTRL_OFS, RST | 32'h1);
				u_host.bus_write(PWR_CTRL_OFS, RST);
			end
		join
		check_word(n, XCVR_RST_CYCLES);
		rd_chk(PWR_CTRL_OFS, 32'h1);
		for (int i = 0; i < 3; i++)
		begin
			u_host.bus_write(PWR_CTRL_OFS, cfg[i]);
			check_bit(wake_event_pin_oe, cfg[i][6]);
			check_bit(pin_level, !act[i]);
			fire(evt[i]);
			tick(3);
			check_bit(wake_interrupt, 1'b1);
			check_bit(pin_level, act[i]);
			tick(20);
			check_bit(pin_level, act[i]);
			u_host.bus_write(PWR_CTRL_OFS, cfg[i] | stat[i]);
			check_bit(wake_interrupt, 1'b0);
			check_bit(pin_level, !act[i]);
		end
		u_host.bus_write(PWR_CTRL_OFS, WOL);
		fire(1'b0);
		tick(3);
		check_bit(wake_interrupt, 1'b1);
		check_bit(pin_level, 1'b1);
		u_host.bus_write(PWR_CTRL_OFS, WOL | 32'h20);
		u_host.bus_write(PWR_CTRL_OFS, ED | PP | POL | EN | 32'h8);
		fork
			count_high(1'b1, n);
			fire(1'b1);
		join
		check_word(n, PULSE);
		check_bit(wake_interrupt, 1'b1);
		u_host.bus_write(PWR_CTRL_OFS, PP | POL | EN | 32'h10);
		@(posedge clk);
		soft_reset <= 1'b1;
		@(posedge clk);
		soft_reset <= 1'b0;
		tick(2);
		rd_chk(PWR_CTRL_OFS, PP | POL | 32'h1);
		for (int i = 0; i < 2; i++)
		begin
			mode_word = (i ? 32'h2000 : 32'h1000) | PP | POL;
			u_host.bus_write(PWR_CTRL_OFS, mode_word);
			tick(2);
			check_bit(device_ready, 1'b0);
			check_bit(frame_detect_enable, i == 0);
			check_bit(energy_detect_enable, i == 1);
			rd_chk(PWR_CTRL_OFS, mode_word);
			u_host.bus_write(WAKE_TRIGGER_OFS, 32'h5A);
			wait_ready();
			rd_chk(PWR_CTRL_OFS, PP | POL | 32'h1);
		end
		report_and_stop();
	end
endmodule
